// *** src/ipc_pkg.sv ***
package ipc_pkg;
  localparam int unsigned IRQ_NUM = 60;
  localparam int unsigned ADDR_W = 4;
  localparam logic [ADDR_W-1:0] CLR0_OFFSET = 4'h0;
  localparam logic [ADDR_W-1:0] CLR1_OFFSET = 4'h4;
  localparam logic [ADDR_W-1:0] SET0_OFFSET = 4'h8;
  localparam logic [ADDR_W-1:0] SET1_OFFSET = 4'hC;
  // Implemented interrupt lines, as bits 0..59 across the two words
  localparam logic [31:0] MAP0 = 32'h7FFF_00FF;
  localparam logic [31:0] MAP1 = 32'h0FFF_FFEF;
  localparam logic [63:0] IRQ_MAP = {MAP1, MAP0};
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [31:0] DATA_ZERO = 32'h0000_0000;
endpackage : ipc_pkg

// *** src/ipc_pend_bit.sv ***
module ipc_pend_bit
  import ipc_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic src_set_i,
  input wire logic sw_set_i,
  input wire logic sw_clr_i,
  input wire logic active_i,
  output logic pend_o
);
  logic pend_q;
  logic pend_d;

  // Set wins over a clear in the same cycle so no event is lost
  always_comb begin
    pend_d = pend_q;
    if (sw_clr_i && !active_i) begin
      pend_d = 1'b0;
    end
    if (src_set_i || sw_set_i) begin
      pend_d = 1'b1;
    end
  end

  // Reset value is undefined in hardware; zero chosen for determinism
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pend_q <= 1'b0;
    end else begin
      pend_q <= pend_d;
    end
  end

  assign pend_o = pend_q;
endmodule : ipc_pend_bit

// *** src/ipc_regs.sv ***
// Contract
// - Writing one clears the interrupt's pending state
// - Clear ignored while interrupt is being serviced
// - Writing zero leaves pending state unchanged
// - Read returns live pending state per bit
// - Word1 bits 27..5 map to irq 59..37
// - Word1 bits 3..0 map to irq 35..32
// - Same pending state seen by set registers
//
// Decided for this implementation: register access over AXI4-Lite and the register addresses.
module ipc_regs
  import ipc_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic [63:0] irq_src_i,
  input wire logic [63:0] irq_active_i,
  output logic [63:0] irq_pending_o,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic aw_got_q, aw_got_d, w_got_q, w_got_d;
  logic [ADDR_W-1:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic rvalid_q, rvalid_d;
  logic [1:0] rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic wr_fire;
  logic [31:0] wmask;
  logic [63:0] sw_clr, sw_set, pend;
  logic [31:0] pend_w0, pend_w1;

  assign s_axi_awready = !aw_got_q && !bvalid_q;
  assign s_axi_wready = !w_got_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign wr_fire = aw_got_q && w_got_q && !bvalid_q;

  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wmask[b*8 +: 8] = {8{wstrb_q[b]}};
    end
  end

  // Only a written one on a mapped line acts; zeros and gaps do nothing
  always_comb begin
    sw_clr = '0;
    sw_set = '0;
    if (wr_fire) begin
      unique case (awaddr_q)
        CLR0_OFFSET: sw_clr[31:0] = wdata_q & wmask & MAP0;
        CLR1_OFFSET: sw_clr[63:32] = wdata_q & wmask & MAP1;
        SET0_OFFSET: sw_set[31:0] = wdata_q & wmask & MAP0;
        SET1_OFFSET: sw_set[63:32] = wdata_q & wmask & MAP1;
        default: ;
      endcase
    end
  end

  genvar g;
  generate
    for (g = 0; g < 64; g++) begin : g_bit
      if (IRQ_MAP[g]) begin : g_impl
        ipc_pend_bit u_bit (
          .sys_clk_i(sys_clk_i),
          .sys_rst_i(sys_rst_i),
          .src_set_i(irq_src_i[g]),
          .sw_set_i(sw_set[g]),
          .sw_clr_i(sw_clr[g]),
          .active_i(irq_active_i[g]),
          .pend_o(pend[g])
        );
      end else begin : g_gap
        assign pend[g] = 1'b0;
      end
    end
  endgenerate

  assign pend_w0 = pend[31:0];
  assign pend_w1 = pend[63:32];
  assign irq_pending_o = pend;

  always_comb begin
    aw_got_d = aw_got_q;
    w_got_d = w_got_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_got_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_got_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    if (wr_fire) begin
      aw_got_d = 1'b0;
      w_got_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = (awaddr_q[1:0] == 2'b00) ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
  end

  // Clear and set words share one pending store
  always_comb begin
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rresp_d = RESP_OKAY;
      unique case (s_axi_araddr)
        CLR0_OFFSET, SET0_OFFSET: rdata_d = pend_w0;
        CLR1_OFFSET, SET1_OFFSET: rdata_d = pend_w1;
        default: begin
          rdata_d = DATA_ZERO;
          rresp_d = RESP_SLVERR;
        end
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= DATA_ZERO;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= DATA_ZERO;
    end else begin
      aw_got_q <= aw_got_d;
      w_got_q <= w_got_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

  a_clear_takes: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (sw_clr[5] && !irq_active_i[5] && !irq_src_i[5] && !sw_set[5]) |=> !pend[5])
    else $error("clear did not remove pending");
  a_clear_blocked: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (sw_clr[4] && irq_active_i[4] && pend[4]) |=> pend[4])
    else $error("clear acted on serviced irq");
  a_zero_keeps: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (!sw_clr[20] && pend[20]) |=> pend[20])
    else $error("pending lost without clear");
  a_read_live: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (s_axi_arvalid && s_axi_arready && s_axi_araddr == CLR1_OFFSET) |=> (s_axi_rdata == $past(pend_w1)))
    else $error("read data not pending state");
  a_map_hi: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (wr_fire && awaddr_q == CLR1_OFFSET && wdata_q[27] && wstrb_q[3]) |-> sw_clr[59])
    else $error("bit 27 not mapped to irq 59");
  a_map_lo: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (wr_fire && awaddr_q == CLR1_OFFSET && wdata_q[0] && wstrb_q[0]) |-> sw_clr[32] && !sw_clr[36])
    else $error("bit 0 not mapped to irq 32");
  a_gap_zero: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (pend[15:8] == 8'h00) && !pend[31] && !pend[36] && (pend[63:60] == 4'h0))
    else $error("unmapped line pending");
  a_shared_view: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (s_axi_arvalid && s_axi_arready && s_axi_araddr == SET0_OFFSET) |=> (s_axi_rdata == $past(pend_w0)))
    else $error("set view differs from pending");

  // Bus-side views of the same rules except a_clear_hi, which checks sw_clr[59] directly, so a decode slip shows up at the register word
  a_clear_hi: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (sw_clr[59] && !irq_active_i[59] && !irq_src_i[59] && !sw_set[59]) |=> !pend[59])
    else $error("clear did not remove pending on irq 59");
  a_serviced_kept: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (wr_fire && awaddr_q == CLR0_OFFSET && wdata_q[4] && wstrb_q[0] && irq_active_i[4] && pend[4]) |=> pend[4])
    else $error("written clear removed a serviced irq");
  a_zero_no_clear: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (wr_fire && awaddr_q == CLR1_OFFSET && !wdata_q[20] && pend[52]) |=> pend[52])
    else $error("written zero removed pending");
  a_read_word0: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (s_axi_arvalid && s_axi_arready && s_axi_araddr == CLR0_OFFSET) |=> (s_axi_rdata == $past(pend_w0)))
    else $error("word0 read data not pending state");
  a_map_mid: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (wr_fire && awaddr_q == CLR1_OFFSET && wdata_q[5] && wstrb_q[0]) |-> sw_clr[37])
    else $error("bit 5 not mapped to irq 37");
  a_word0_hi: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (wr_fire && awaddr_q == CLR0_OFFSET && wdata_q[30] && wstrb_q[3]) |-> sw_clr[30] && !sw_clr[31])
    else $error("word0 bit 30 not mapped to irq 30");
  a_set_view_hi: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (s_axi_arvalid && s_axi_arready && s_axi_araddr == SET1_OFFSET) |=> (s_axi_rdata == $past(pend_w1)))
    else $error("set view of word1 differs from pending");
endmodule : ipc_regs

// *** verif/ipc_regs_bench.sv ***
module ipc_regs_bench import ipc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [63:0] src = '0;
  logic [63:0] act = '0;
  logic [63:0] pend;
  logic [ADDR_W-1:0] awaddr = '0;
  logic [ADDR_W-1:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = 4'hF;
  logic [31:0] rdata;
  logic [1:0] bresp;
  logic [1:0] rresp;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [63:0] exp_q;
  int n_errors = 0;
  int comparisons = 0;
  int cycles = 0;

  always #2 sys_clk_i = ~sys_clk_i;

  ipc_regs dut_u (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .irq_src_i(src), .irq_active_i(act),
    .irq_pending_o(pend), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  task automatic test_done();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : test_done

  // Hang guard: whole run needs under a hundred cycles
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      test_done();
    end
  end

  task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // Ready is sampled at the negedge, where it already equals its value at the next edge
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    logic aw, w, b;
    @(posedge sys_clk_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge sys_clk_i);
      aw = awvalid & awready;
      w = wvalid & wready;
      b = bvalid & bready;
      if (b) chk("bresp", {62'h0, bresp}, {62'h0, er});
      @(posedge sys_clk_i);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (b) bready <= 1'b0;
    end while (!b);
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    logic ar, r;
    @(posedge sys_clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge sys_clk_i);
      ar = arvalid & arready;
      r = rvalid & rready;
      d = rdata;
      if (r) chk("rresp", {62'h0, rresp}, {62'h0, er});
      @(posedge sys_clk_i);
      if (ar) arvalid <= 1'b0;
      if (r) rready <= 1'b0;
    end while (!r);
  endtask : rd

  task automatic pchk(input logic [63:0] exp);
    @(negedge sys_clk_i);
    chk("pending", pend, exp);
  endtask : pchk

  task automatic set_all();
    logic [31:0] d;
    @(posedge sys_clk_i);
    src <= '1;
    @(posedge sys_clk_i);
    src <= '0;
    repeat (2) @(posedge sys_clk_i);
    pchk(IRQ_MAP);
    rd(CLR0_OFFSET, d);
    chk("clr0", {32'h0, d}, {32'h0, MAP0});
    rd(CLR1_OFFSET, d);
    chk("clr1", {32'h0, d}, {32'h0, MAP1});
  endtask : set_all

  // Misaligned or lane-masked writes must leave every pending bit alone
  task automatic bad_access();
    logic [31:0] d;
    wr(4'h2, 32'h0000_00FF, RESP_SLVERR);
    wstrb <= 4'h0;
    wr(CLR0_OFFSET, 32'h0000_00FF);
    wstrb <= 4'hF;
    pchk(IRQ_MAP);
    rd(4'h6, d, RESP_SLVERR);
    chk("bad_rd", {32'h0, d}, 64'h0000_0000_0000_0000);
  endtask : bad_access

  // Bit 4 stays in service while bits 7..4 are cleared
  task automatic clear_word0();
    logic [31:0] d;
    act <= 64'h0000_0000_0000_0010;
    wr(CLR0_OFFSET, 32'h0000_00F0);
    exp_q = IRQ_MAP & ~64'h0000_0000_0000_00E0;
    pchk(exp_q);
    wr(CLR0_OFFSET, 32'h7FFF_0000);
    exp_q = exp_q & ~64'h0000_0000_7FFF_0000;
    pchk(exp_q);
    rd(SET0_OFFSET, d);
    chk("set0", {32'h0, d}, {32'h0, exp_q[31:0]});
    act <= '0;
    wr(CLR0_OFFSET, 32'h0000_0010);
    exp_q[4] = 1'b0;
    pchk(exp_q);
  endtask : clear_word0

  task automatic clear_word1();
    logic [31:0] d;
    wr(CLR1_OFFSET, 32'h0800_0021);
    exp_q[63:32] = MAP1 & ~32'h0800_0021;
    pchk(exp_q);
    wr(CLR1_OFFSET, MAP1);
    exp_q[63:32] = 32'h0000_0000;
    pchk(exp_q);
    rd(SET1_OFFSET, d);
    chk("set1", {32'h0, d}, 64'h0000_0000_0000_0000);
    wr(CLR0_OFFSET, 32'h0000_0000);
    pchk(exp_q);
    wr(SET1_OFFSET, 32'h0000_0001);
    exp_q[32] = 1'b1;
    rd(CLR1_OFFSET, d);
    chk("clr1_set", {32'h0, d}, {32'h0, exp_q[63:32]});
    pchk(exp_q);
  endtask : clear_word1

  initial begin
    repeat (16) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    pchk(64'h0000_0000_0000_0000);
    set_all();
    bad_access();
    clear_word0();
    clear_word1();
    test_done();
  end
endmodule : ipc_regs_bench
